// ### design/impedance_sweep_sequencer_status.sv
// Sweep sequencer, settling timer, status flags and result registers
// Notes on behaviour
// [R1] Point count is 9 bits D8..D0; upper bits D15..D9 ignored.
// [R2] Host programs a point count of at most 511.
// [R3] Point count keeps its value over power-up and reset command.
// [R4] Sweep bounded by start word, increment word and point count.
// [R5] Programmed excitation cycles elapse after start/step/repeat before ADC starts.
// [R6] Settling count is 9 bits D8..D0; D15..D11 ignored.
// [R7] Multiplier D10..D9: 00 x1, 01 x2, 11 x4, 10 reserved.
// [R8] Longest effective settling delay is 2044 excitation cycles.
// [R9] Settling count and multiplier keep value over power-up and reset command.
// [R10] 1024 samples per point; real and imaginary go to 0x94..0x97.
// [R11] Per-point conversion takes roughly 1 ms.
// [R12] Status bits: D0 temperature valid, D1 point valid, D2 sweep done.
// [R13] Point-valid flag sets when the current point finishes.
// [R14] Point-valid clears on power-up, start, step, repeat and reset.
// [R15] Sweep-done flag sets when the final point finishes.
// [R16] Sweep-done clears on power-up, start and reset.
// [R17] Temperature-valid sets on conversion end, clears on measure command.
// [R18] Temperature at 0x92/0x93, two's complement, sign at bit 13.
// [R19] Results are 16-bit two's complement, untouched by any reset.
// [R20] Host trusts results only while point-valid reads set.
// [R21] Reset command aborts the sweep; initialize needed before restarting.
// [R22] Step command advances a point, then waits settling before ADC.
// [R23] Repeat command re-measures the current point without advancing.
// [R24] Point counter cleared by start, advanced by step, compared for done.
// [R25] Status bits D3..D7 read zero; status writes change nothing.
`timescale 1ns/1ps
module impedance_sweep_sequencer_status #(
  parameter int SAMPLES = imp_sweep_pkg::SAMPLES_PER_POINT,
  parameter int SAMPLE_DIV = imp_sweep_pkg::SAMPLE_DIV
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_RD_I,
  output logic [7:0] REG_RDATA_O,
  input wire logic CMD_INIT_I,
  input wire logic CMD_START_I,
  input wire logic CMD_STEP_I,
  input wire logic CMD_REPEAT_I,
  input wire logic CMD_RESET_I,
  input wire logic CMD_TEMP_I,
  input wire logic EXC_CYCLE_I,
  input wire logic REF_COS_NEG_I,
  input wire logic REF_SIN_NEG_I,
  input wire logic [imp_sweep_pkg::ADC_W-1:0] ADC_DATA_I,
  input wire logic TEMP_DONE_I,
  input wire logic [imp_sweep_pkg::TEMP_W-1:0] TEMP_DATA_I,
  output logic FREQ_STEP_O,
  output logic [imp_sweep_pkg::COUNT_W-1:0] POINT_INDEX_O,
  output logic ADC_START_O,
  output logic BUSY_O
);
  localparam int DIV_W = $clog2(SAMPLE_DIV + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SAMPLE_DIV - 1);

  imp_sweep_pkg::seq_state_t state_reg;
  logic [imp_sweep_pkg::COUNT_W-1:0] point_count_reg;
  logic [imp_sweep_pkg::COUNT_W-1:0] settle_count_reg;
  logic [1:0] settle_mult_reg;
  logic [imp_sweep_pkg::COUNT_W-1:0] point_idx_reg;
  logic [imp_sweep_pkg::SETTLE_W-1:0] settle_eff;
  logic [imp_sweep_pkg::SETTLE_W-1:0] settle_left_reg;
  logic [DIV_W-1:0] div_reg;
  logic sample_tick;
  logic conv_done;
  logic conv_clear;
  logic signed [imp_sweep_pkg::RES_W-1:0] real_word;
  logic signed [imp_sweep_pkg::RES_W-1:0] imag_word;
  logic [imp_sweep_pkg::TEMP_W-1:0] temp_reg;
  logic temp_valid_flag;
  logic point_data_valid_flag;
  logic sweep_done_flag;
  logic go_start;
  logic go_step;
  logic go_repeat;
  logic last_point;
  logic [7:0] rdata_next;

  // Start, step and repeat are honoured only while waiting; busy phases ignore them
  assign go_start = state_reg == imp_sweep_pkg::ST_READY && CMD_START_I && !CMD_RESET_I;
  assign go_step = state_reg == imp_sweep_pkg::ST_READY && CMD_STEP_I && !CMD_START_I
    && !CMD_RESET_I && point_idx_reg != point_count_reg;
  assign go_repeat = state_reg == imp_sweep_pkg::ST_READY && CMD_REPEAT_I && !CMD_START_I
    && !CMD_STEP_I && !CMD_RESET_I;
  assign last_point = point_idx_reg == point_count_reg; // [R24]

  // Effective settling count; reserved code falls back to x1
  always_comb
  begin
    case (settle_mult_reg) // [R7]
      imp_sweep_pkg::MULT_X2: settle_eff = {1'b0, settle_count_reg, 1'b0};
      imp_sweep_pkg::MULT_X4: settle_eff = {settle_count_reg, 2'b00};
      default: settle_eff = {2'b00, settle_count_reg};
    endcase
  end

  // Programmed counts carry no reset: they survive power-up and reset command
  always_ff @(posedge CLK_I)
  begin
    if (REG_WR_I)
    begin
      case (REG_ADDR_I)
        imp_sweep_pkg::ADDR_POINT_HI: point_count_reg[8] <=
          REG_WDATA_I[imp_sweep_pkg::COUNT_MSB_POS]; // [R1] [R3]
        imp_sweep_pkg::ADDR_POINT_LO: point_count_reg[7:0] <= REG_WDATA_I; // [R1]
        imp_sweep_pkg::ADDR_SETTLE_HI:
        begin
          settle_count_reg[8] <= REG_WDATA_I[imp_sweep_pkg::COUNT_MSB_POS]; // [R6] [R9]
          settle_mult_reg <= REG_WDATA_I[imp_sweep_pkg::MULT_LSB_POS +: 2]; // [R7] [R9]
        end
        imp_sweep_pkg::ADDR_SETTLE_LO: settle_count_reg[7:0] <= REG_WDATA_I; // [R6]
        default: ;
      endcase
    end
  end

  // Sequencer
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      state_reg <= imp_sweep_pkg::ST_IDLE;
    end
    else if (CMD_RESET_I)
    begin
      state_reg <= imp_sweep_pkg::ST_IDLE; // [R21]
    end
    else
    begin
      case (state_reg)
        imp_sweep_pkg::ST_IDLE:
          if (CMD_INIT_I)
          begin
            state_reg <= imp_sweep_pkg::ST_READY;
          end
        imp_sweep_pkg::ST_READY:
          if (go_start || go_step || go_repeat)
          begin
            state_reg <= imp_sweep_pkg::ST_SETTLE; // [R5] [R22] [R23]
          end
        imp_sweep_pkg::ST_SETTLE:
          if (settle_left_reg == '0)
          begin
            state_reg <= imp_sweep_pkg::ST_CONVERT; // [R5]
          end
        imp_sweep_pkg::ST_CONVERT:
          if (conv_done)
          begin
            state_reg <= imp_sweep_pkg::ST_READY;
          end
        default: state_reg <= imp_sweep_pkg::ST_IDLE;
      endcase
    end
  end

  // Settling timer counts excitation cycles from the synthesizer
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      settle_left_reg <= '0;
    else if (go_start || go_step || go_repeat)
      settle_left_reg <= settle_eff; // [R5] [R8]
    else if (state_reg == imp_sweep_pkg::ST_SETTLE && EXC_CYCLE_I && settle_left_reg != '0)
      settle_left_reg <= settle_left_reg - 1'b1;
  end

  // Point counter; start and increment words live in the synthesizer
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      point_idx_reg <= '0;
      FREQ_STEP_O <= 1'b0;
    end
    else
    begin
      FREQ_STEP_O <= go_step; // [R4] [R22]
      if (go_start)
      begin
        point_idx_reg <= '0; // [R24]
      end
      else if (go_step)
      begin
        point_idx_reg <= point_idx_reg + 1'b1; // [R24] [R22]
      end
    end
  end

  // Sample-rate enable, about one sample per microsecond
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      div_reg <= '0;
    else if (state_reg != imp_sweep_pkg::ST_CONVERT || div_reg == DIV_LAST)
      div_reg <= '0;
    else
      div_reg <= div_reg + 1'b1;
  end
  assign sample_tick = state_reg == imp_sweep_pkg::ST_CONVERT && div_reg == DIV_LAST; // [R11]
  assign conv_clear = state_reg != imp_sweep_pkg::ST_CONVERT;

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      ADC_START_O <= 1'b0;
    else
      ADC_START_O <= state_reg == imp_sweep_pkg::ST_SETTLE && settle_left_reg == '0
        && !CMD_RESET_I;
  end

  dft_correlator #(
    .SAMPLES(SAMPLES),
    .DATA_W(imp_sweep_pkg::ADC_W),
    .RES_W(imp_sweep_pkg::RES_W)
  ) u_corr (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .clear_i(conv_clear),
    .sample_en_i(sample_tick),
    .cos_neg_i(REF_COS_NEG_I),
    .sin_neg_i(REF_SIN_NEG_I),
    .data_i(ADC_DATA_I),
    .done_o(conv_done), // [R10]
    .real_o(real_word), // [R19]
    .imag_o(imag_word)
  );

  // Flags: a set in the same cycle as a clear wins
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      point_data_valid_flag <= imp_sweep_pkg::FLAG_RESET; // [R14]
    else if (conv_done && state_reg == imp_sweep_pkg::ST_CONVERT)
      point_data_valid_flag <= 1'b1; // [R13]
    else if (go_start || go_step || go_repeat || CMD_RESET_I)
      point_data_valid_flag <= 1'b0; // [R14]
  end

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      sweep_done_flag <= imp_sweep_pkg::FLAG_RESET; // [R16]
    else if (conv_done && state_reg == imp_sweep_pkg::ST_CONVERT && last_point)
      sweep_done_flag <= 1'b1; // [R15]
    else if (go_start || CMD_RESET_I)
      sweep_done_flag <= 1'b0; // [R16]
  end

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      temp_valid_flag <= imp_sweep_pkg::FLAG_RESET;
    else if (TEMP_DONE_I)
      temp_valid_flag <= 1'b1; // [R17]
    else if (CMD_TEMP_I)
      temp_valid_flag <= 1'b0; // [R17]
  end

  always_ff @(posedge CLK_I)
  begin
    if (TEMP_DONE_I)
      temp_reg <= TEMP_DATA_I; // [R18]
  end

  // Read mux; don't-care and reserved bits read zero, status is never written
  always_comb
  begin
    rdata_next = 8'h00;
    case (REG_ADDR_I)
      imp_sweep_pkg::ADDR_POINT_HI: rdata_next = {7'h00, point_count_reg[8]}; // [R1]
      imp_sweep_pkg::ADDR_POINT_LO: rdata_next = point_count_reg[7:0];
      imp_sweep_pkg::ADDR_SETTLE_HI: rdata_next = {5'h00, settle_mult_reg, settle_count_reg[8]};
      imp_sweep_pkg::ADDR_SETTLE_LO: rdata_next = settle_count_reg[7:0];
      imp_sweep_pkg::ADDR_STATUS: rdata_next = {5'h00, sweep_done_flag, point_data_valid_flag,
        temp_valid_flag}; // [R12] [R25]
      imp_sweep_pkg::ADDR_TEMP_HI: rdata_next = {2'b00, temp_reg[13:8]}; // [R18]
      imp_sweep_pkg::ADDR_TEMP_LO: rdata_next = temp_reg[7:0];
      imp_sweep_pkg::ADDR_REAL_HI: rdata_next = real_word[15:8]; // [R10] [R19]
      imp_sweep_pkg::ADDR_REAL_LO: rdata_next = real_word[7:0];
      imp_sweep_pkg::ADDR_IMAG_HI: rdata_next = imag_word[15:8];
      imp_sweep_pkg::ADDR_IMAG_LO: rdata_next = imag_word[7:0];
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      REG_RDATA_O <= 8'h00;
    else if (REG_RD_I)
      REG_RDATA_O <= rdata_next;
  end

  assign POINT_INDEX_O = point_idx_reg;
  assign BUSY_O = state_reg == imp_sweep_pkg::ST_SETTLE || state_reg == imp_sweep_pkg::ST_CONVERT;

  // Checks; helper counts excitation cycles seen while settling
  logic [imp_sweep_pkg::SETTLE_W-1:0] seen_reg;
  logic [imp_sweep_pkg::SETTLE_W-1:0] target_reg;
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      seen_reg <= '0;
      target_reg <= '0;
    end
    else if (go_start || go_step || go_repeat)
    begin
      seen_reg <= '0;
      target_reg <= settle_eff;
    end
    else if (state_reg == imp_sweep_pkg::ST_SETTLE && EXC_CYCLE_I && settle_left_reg != '0)
    begin
      seen_reg <= seen_reg + 1'b1;
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  AST_SETTLE_ELAPSED: assert property (ADC_START_O |-> seen_reg == target_reg) // [R5]
    else $error("ADC started before settling cycles elapsed");
  AST_SETTLE_MAX: assert property (settle_left_reg <= 11'(imp_sweep_pkg::MAX_SETTLE)) // [R8]
    else $error("Effective settling count above limit");
  AST_MULT_X4: assert property ((go_start && settle_mult_reg == imp_sweep_pkg::MULT_X4)
    |=> settle_left_reg == {$past(settle_count_reg), 2'b00}) // [R7]
    else $error("x4 multiplier not applied");
  AST_PDV_SET: assert property ((conv_done && state_reg == imp_sweep_pkg::ST_CONVERT)
    |=> point_data_valid_flag && state_reg == imp_sweep_pkg::ST_READY) // [R13]
    else $error("Point valid flag not set at point end");
  AST_PDV_CLEAR: assert property ((go_step || go_repeat)
    |=> !point_data_valid_flag [*2]) // [R14]
    else $error("Point valid flag not cleared by command");
  AST_DONE_SET: assert property ((conv_done && state_reg == imp_sweep_pkg::ST_CONVERT
    && point_idx_reg == point_count_reg) |=> sweep_done_flag) // [R15]
    else $error("Sweep done flag missed on final point");
  AST_DONE_CLEAR: assert property ((go_start || (CMD_RESET_I && !conv_done))
    |=> !sweep_done_flag && !point_data_valid_flag) // [R16]
    else $error("Sweep done flag not cleared");
  AST_TEMP_FLAG: assert property ((CMD_TEMP_I && !TEMP_DONE_I) |=> !temp_valid_flag) // [R17]
    else $error("Temperature flag not cleared by measure command");
  AST_STEP_ADVANCE: assert property (go_step |=> point_idx_reg == $past(point_idx_reg) + 1'b1
    && FREQ_STEP_O) // [R24]
    else $error("Step did not advance point counter");
  AST_REPEAT_HOLD: assert property (go_repeat |=> $stable(point_idx_reg) && !FREQ_STEP_O) // [R23]
    else $error("Repeat moved the point counter");
  AST_STATUS_RSVD: assert property ((REG_RD_I && REG_ADDR_I == imp_sweep_pkg::ADDR_STATUS)
    |=> REG_RDATA_O[7:3] == 5'h00) // [R25]
    else $error("Reserved status bits not zero");
  AST_RESET_ABORT: assert property (CMD_RESET_I |=> state_reg == imp_sweep_pkg::ST_IDLE
    ##1 (!BUSY_O)) // [R21]
    else $error("Reset command did not abort sweep");

  COV_FULL_POINT: cover property (go_start ##[1:1000] ADC_START_O);
  COV_SWEEP_DONE: cover property ($rose(sweep_done_flag));
  COV_REPEAT: cover property (go_repeat);
  COV_TEMP: cover property (CMD_TEMP_I ##[1:50] TEMP_DONE_I);
endmodule

// ### design/imp_sweep_pkg.sv
// Shared constants and types for the impedance sweep sequencer
package imp_sweep_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_POINT_HI = 8'h88;
  localparam logic [7:0] ADDR_POINT_LO = 8'h89;
  localparam logic [7:0] ADDR_SETTLE_HI = 8'h8A;
  localparam logic [7:0] ADDR_SETTLE_LO = 8'h8B;
  localparam logic [7:0] ADDR_STATUS = 8'h8F;
  localparam logic [7:0] ADDR_TEMP_HI = 8'h92;
  localparam logic [7:0] ADDR_TEMP_LO = 8'h93;
  localparam logic [7:0] ADDR_REAL_HI = 8'h94;
  localparam logic [7:0] ADDR_REAL_LO = 8'h95;
  localparam logic [7:0] ADDR_IMAG_HI = 8'h96;
  localparam logic [7:0] ADDR_IMAG_LO = 8'h97;
  // Field layout
  localparam int COUNT_W = 9;
  localparam int COUNT_MSB_POS = 0;
  localparam int MULT_LSB_POS = 1;
  localparam int STAT_TEMP_POS = 0;
  localparam int STAT_PDV_POS = 1;
  localparam int STAT_DONE_POS = 2;
  localparam int TEMP_W = 14;
  localparam int ADC_W = 12;
  localparam int RES_W = 16;
  localparam int SETTLE_W = 11;
  // Settling multiplier codes
  localparam logic [1:0] MULT_X1 = 2'h0;
  localparam logic [1:0] MULT_X2 = 2'h1;
  localparam logic [1:0] MULT_RSVD = 2'h2;
  localparam logic [1:0] MULT_X4 = 2'h3;
  localparam int MAX_SETTLE = 2044;
  // Reset values of flags
  localparam logic FLAG_RESET = 1'b0;
  // Sampling timing
  localparam int CLK_HZ = 25_000_000;
  localparam int SAMPLE_PERIOD_NS = 1000;
  localparam int SAMPLE_DIV_RAW = (SAMPLE_PERIOD_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int SAMPLE_DIV = (SAMPLE_DIV_RAW < 1) ? 1 : SAMPLE_DIV_RAW;
  localparam int SAMPLES_PER_POINT = 1024;
  typedef enum logic [1:0] {ST_IDLE, ST_READY, ST_SETTLE, ST_CONVERT} seq_state_t;
endpackage

// ### design/dft_correlator.sv
// Sample correlator producing real and imaginary words for one point
`timescale 1ns/1ps
module dft_correlator #(
  parameter int SAMPLES = 1024,
  parameter int DATA_W = 12,
  parameter int RES_W = 16
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic clear_i,
  input wire logic sample_en_i,
  input wire logic cos_neg_i,
  input wire logic sin_neg_i,
  input wire logic signed [DATA_W-1:0] data_i,
  output logic done_o,
  output logic signed [RES_W-1:0] real_o,
  output logic signed [RES_W-1:0] imag_o
);
  localparam int CNT_W = $clog2(SAMPLES);
  // Never narrower than the result word, so short test blocks still elaborate
  localparam int ACC_W = (DATA_W + CNT_W > RES_W) ? DATA_W + CNT_W : RES_W;
  localparam logic [CNT_W-1:0] LAST = CNT_W'(SAMPLES - 1);

  logic signed [ACC_W-1:0] re_reg;
  logic signed [ACC_W-1:0] im_reg;
  logic signed [ACC_W-1:0] re_next;
  logic signed [ACC_W-1:0] im_next;
  logic signed [ACC_W-1:0] ext;
  logic [CNT_W-1:0] cnt_reg;

  always_comb
  begin
    ext = {{(ACC_W-DATA_W){data_i[DATA_W-1]}}, data_i};
    re_next = cos_neg_i ? re_reg - ext : re_reg + ext;
    im_next = sin_neg_i ? im_reg + ext : im_reg - ext;
  end

  // Accumulators wide enough that a full block never wraps
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      re_reg <= '0;
      im_reg <= '0;
      cnt_reg <= '0;
      done_o <= 1'b0;
    end
    else if (clear_i)
    begin
      re_reg <= '0;
      im_reg <= '0;
      cnt_reg <= '0;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      if (sample_en_i)
      begin
        re_reg <= re_next;
        im_reg <= im_next;
        cnt_reg <= cnt_reg + 1'b1;
        if (cnt_reg == LAST)
        begin
          done_o <= 1'b1;
        end
      end
    end
  end

  // Results are not reset; they only change at the end of a block
  always_ff @(posedge clk_i)
  begin
    if (!clear_i && sample_en_i && cnt_reg == LAST)
    begin
      real_o <= re_next[ACC_W-1 -: RES_W];
      imag_o <= im_next[ACC_W-1 -: RES_W];
    end
  end
endmodule

// ### tb/far_side_model.sv
// Model of the excitation source, ADC front end and temperature sensor
`timescale 1ns/1ps
module far_side_model #(
  parameter int EXC_DIV = 4,
  parameter logic [13:0] TEMP_VAL = 14'h3ABC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic temp_req_i,
  output logic exc_cycle_o,
  output logic cos_neg_o,
  output logic sin_neg_o,
  output logic [imp_sweep_pkg::ADC_W-1:0] adc_data_o,
  output logic temp_done_o,
  output logic [imp_sweep_pkg::TEMP_W-1:0] temp_data_o
);
  logic [7:0] div_reg;
  logic [3:0] temp_cnt_reg;
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      div_reg <= 8'h00;
      exc_cycle_o <= 1'b0;
    end
    else
    begin
      div_reg <= (div_reg == 8'(EXC_DIV - 1)) ? 8'h00 : div_reg + 8'h01;
      exc_cycle_o <= (div_reg == 8'h00);
    end
  end
  // Zero samples keep both sums at zero, so results are known without the transform
  assign adc_data_o = '0;
  assign cos_neg_o = div_reg[0];
  assign sin_neg_o = div_reg[1];
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      temp_cnt_reg <= 4'h0;
      temp_done_o <= 1'b0;
    end
    else
    begin
      temp_cnt_reg <= temp_req_i ? 4'h8 : (temp_cnt_reg != 4'h0) ? temp_cnt_reg - 4'h1 : 4'h0;
      temp_done_o <= (temp_cnt_reg == 4'h1);
    end
  end
  // Data only valid in the done cycle; inverse elsewhere so a late sample shows
  assign temp_data_o = temp_done_o ? TEMP_VAL : ~TEMP_VAL;
endmodule

// ### tb/tb.sv
// Self-checking bench for the sweep sequencer and status block
`timescale 1ns/1ps
module tb;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} reg_row_t;
  typedef struct {logic [7:0] hi; logic [7:0] lo; int n;} settle_row_t;
  localparam logic [13:0] TEMP_VAL = 14'h3ABC;
  logic clk, rst_n, reg_wr, reg_rd, exc, cos_neg, sin_neg, temp_done;
  logic freq_step, adc_start, busy;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [5:0] cmd_v;
  logic [imp_sweep_pkg::ADC_W-1:0] adc_data;
  logic [imp_sweep_pkg::TEMP_W-1:0] temp_data;
  logic [imp_sweep_pkg::COUNT_W-1:0] point_idx;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  int n;
  reg_row_t rrows[7] = '{'{8'h88, 8'hFF, 8'h01}, '{8'h89, 8'hA5, 8'hA5},
    '{8'h8A, 8'hFF, 8'h07}, '{8'h8B, 8'h3C, 8'h3C}, '{8'h8F, 8'hFF, 8'h00},
    '{8'h80, 8'h5A, 8'h00}, '{8'h98, 8'h5A, 8'h00}};
  settle_row_t srows[7] = '{'{8'h00, 8'h02, 2}, '{8'h02, 8'h02, 4}, '{8'h06, 8'h02, 8},
    '{8'h04, 8'h02, 2}, '{8'hF8, 8'h03, 3}, '{8'h01, 8'h00, 256}, '{8'h07, 8'hFF, 2044}};
  impedance_sweep_sequencer_status #(.SAMPLES(8), .SAMPLE_DIV(2)) DUT (.CLK_I(clk),
    .RST_N_I(rst_n), .REG_ADDR_I(reg_addr), .REG_WR_I(reg_wr), .REG_WDATA_I(reg_wdata),
    .REG_RD_I(reg_rd), .REG_RDATA_O(reg_rdata), .CMD_INIT_I(cmd_v[0]), .CMD_START_I(cmd_v[1]),
    .CMD_STEP_I(cmd_v[2]), .CMD_REPEAT_I(cmd_v[3]), .CMD_RESET_I(cmd_v[4]),
    .CMD_TEMP_I(cmd_v[5]), .EXC_CYCLE_I(exc), .REF_COS_NEG_I(cos_neg), .REF_SIN_NEG_I(sin_neg),
    .ADC_DATA_I(adc_data), .TEMP_DONE_I(temp_done), .TEMP_DATA_I(temp_data),
    .FREQ_STEP_O(freq_step), .POINT_INDEX_O(point_idx), .ADC_START_O(adc_start), .BUSY_O(busy));
  far_side_model #(.EXC_DIV(4), .TEMP_VAL(TEMP_VAL)) far_side (.clk_i(clk), .rst_n_i(rst_n),
    .temp_req_i(cmd_v[5]), .exc_cycle_o(exc), .cos_neg_o(cos_neg), .sin_neg_o(sin_neg),
    .adc_data_o(adc_data), .temp_done_o(temp_done), .temp_data_o(temp_data));
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string what);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, {8'h00, reg_rdata}, {8'h00, e});
  endtask
  // Launch just after an excitation pulse so the pulse count is unambiguous
  task automatic cmd(input int i);
    @(posedge clk);
    while (exc !== 1'b1)
      @(posedge clk);
    cmd_v[i] <= 1'b1;
    @(posedge clk);
    cmd_v <= 6'h00;
    #1;
  endtask
  task automatic measure(output int cnt);
    cnt = 0;
    for (int i = 0; i < 9000 && adc_start !== 1'b1; i++)
    begin
      @(posedge clk);
      if (exc === 1'b1 && adc_start !== 1'b1)
        cnt++;
    end
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 100 && busy !== 1'b0; i++)
      @(posedge clk);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Whole run is near 10000 cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      error_cnt++;
      give_verdict();
    end
  end
  initial
  begin
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    cmd_v = 6'h00;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk("point index", {7'h00, point_idx}, 16'h0000);
    rd_chk(imp_sweep_pkg::ADDR_STATUS, 8'h00, "status after reset");
    $display("test reset finished");
    foreach (rrows[i])
    begin
      wr(rrows[i].a, rrows[i].d);
      rd_chk(rrows[i].a, rrows[i].e, "register readback");
    end
    $display("test register table finished");
    wr(imp_sweep_pkg::ADDR_POINT_HI, 8'h00);
    wr(imp_sweep_pkg::ADDR_POINT_LO, 8'h01);
    cmd(0);
    foreach (srows[i])
    begin
      wr(imp_sweep_pkg::ADDR_SETTLE_HI, srows[i].hi);
      wr(imp_sweep_pkg::ADDR_SETTLE_LO, srows[i].lo);
      cmd(1);
      measure(n);
      chk("settle pulses", 16'(n), 16'(srows[i].n));
      wait_idle();
      rd_chk(imp_sweep_pkg::ADDR_STATUS, 8'h02, "status point done");
    end
    for (int a = 8'h94; a <= 8'h97; a++)
      rd_chk(8'(a), 8'h00, "result byte");
    $display("test settling table finished");
    wr(imp_sweep_pkg::ADDR_SETTLE_HI, 8'h00);
    wr(imp_sweep_pkg::ADDR_SETTLE_LO, 8'h01);
    cmd(2);
    chk("freq step", {15'h0000, freq_step}, 16'h0001);
    measure(n);
    rd_chk(imp_sweep_pkg::ADDR_STATUS, 8'h00, "status during step");
    wait_idle();
    rd_chk(imp_sweep_pkg::ADDR_STATUS, 8'h06, "status last point");
    chk("point index", {7'h00, point_idx}, 16'h0001);
    cmd(3);
    measure(n);
    rd_chk(imp_sweep_pkg::ADDR_STATUS, 8'h04, "status during repeat");
    wait_idle();
    chk("point index", {7'h00, point_idx}, 16'h0001);
    cmd(2);
    chk("busy on extra step", {15'h0000, busy}, 16'h0000);
    chk("freq step refused", {15'h0000, freq_step}, 16'h0000);
    cmd(1);
    measure(n);
    rd_chk(imp_sweep_pkg::ADDR_STATUS, 8'h00, "status after start");
    chk("point index", {7'h00, point_idx}, 16'h0000);
    wait_idle();
    $display("test step and repeat finished");
    wr(imp_sweep_pkg::ADDR_SETTLE_LO, 8'h40);
    cmd(1);
    repeat (10) @(posedge clk);
    cmd(4);
    chk("busy after reset cmd", {15'h0000, busy}, 16'h0000);
    rd_chk(imp_sweep_pkg::ADDR_STATUS, 8'h00, "status after reset cmd");
    rd_chk(imp_sweep_pkg::ADDR_POINT_LO, 8'h01, "count kept");
    rd_chk(imp_sweep_pkg::ADDR_SETTLE_LO, 8'h40, "settle kept");
    cmd(1);
    chk("start before init", {15'h0000, busy}, 16'h0000);
    $display("test reset command finished");
    cmd(5);
    repeat (12) @(posedge clk);
    rd_chk(imp_sweep_pkg::ADDR_STATUS, 8'h01, "temp flag set");
    rd_chk(imp_sweep_pkg::ADDR_TEMP_HI, {2'b00, TEMP_VAL[13:8]}, "temp high");
    rd_chk(imp_sweep_pkg::ADDR_TEMP_LO, TEMP_VAL[7:0], "temp low");
    // Second measurement must drop the flag that the first one raised
    cmd(5);
    rd_chk(imp_sweep_pkg::ADDR_STATUS, 8'h00, "temp flag cleared");
    $display("test temperature finished");
    give_verdict();
  end
endmodule
